//--- hdl/ddc_cfg_reg.sv
`timescale 1ns/1ps
module ddc_cfg_reg #(
  parameter logic [7:0] RESET_VALUE = 8'h00,
  parameter logic [7:0] WRITE_MASK = 8'hff
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic wr_en,
  input wire logic [7:0] wdata,
  output logic [7:0] q
);

  // Reserved bits are read-only zero whatever software writes
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      q <= RESET_VALUE;
    end else if (wr_en) begin
      q <= wdata & WRITE_MASK;
    end
  end

endmodule

//--- hdl/ddc_dynamics_config.sv
// Overview of operation
// - Clock select 0 runs activity logic from the oscillator, 1 from the bit clock, 2 from the control clock.
// - Clock select 3 hands the activity clock to the separate counter, source and generator registers.
// - The external clock rate code maps 0/1/2/3 to 24.576/6.144/12.288/18.432 MHz and must match reality.
// - The phase-one enable lets the jack comparator trigger the first detection phase, else blocks it.
// - Limiter detection uses max of both, channel one, channel zero or the average for codes 0 to 3.
// - Limiter gain goes to both, channel one, channel zero or neither for codes 0 to 3.
// - Upper nibble bits enable gain control on channels one to four from the top bit down.
// - Lower nibble bits enable compression on channels one to four from bit three down.
// - The power limiter acts only while its enable bit is set and is bypassed otherwise.
// - The attenuation code selects 0 dB plus 6 dB per step, up to 42 dB at code 7.
// - Source bit clear takes attenuation from the pin and code; set maps analog readings by table.
// - Recovery clear only holds or raises attenuation; set lets it fall once the supply recovers.
`timescale 1ns/1ps
module ddc_dynamics_config (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic jack_comparator,
  input wire logic attenuation_pin,
  input wire logic [7:0] analog_reading,
  input wire logic analog_reading_valid,
  input wire logic signed [15:0] playback_channel_zero,
  input wire logic signed [15:0] playback_channel_one,
  output logic activity_clk_use_osc,
  output logic activity_clk_use_bit_clock,
  output logic activity_clk_use_control_port_clock,
  output logic activity_clk_use_custom,
  output logic [1:0] activity_ext_clock_rate,
  output logic [15:0] activity_ext_clock_khz,
  output logic detect_phase_one_trigger,
  output logic [15:0] limiter_detect_level,
  output logic limiter_apply_ch0,
  output logic limiter_apply_ch1,
  output logic [3:0] gain_ctrl_enable,
  output logic [3:0] compress_enable,
  output logic power_limiter_active,
  output logic [2:0] power_limiter_attenuation,
  output logic [5:0] power_limiter_atten_db
);

  logic [7:0] act_cfg;
  logic [7:0] lim_cfg;
  logic [7:0] agc_cfg;
  logic [7:0] pwr_cfg;
  logic wr_act, wr_lim, wr_agc, wr_pwr;
  logic jack_meta, jack_sync, jack_prev;
  logic pin_meta, pin_sync;
  logic [15:0] abs_ch0, abs_ch1;
  logic [16:0] abs_sum;
  logic [15:0] next_level;
  logic [2:0] lut_code;
  logic [2:0] target_code;
  logic target_update;
  logic [2:0] next_atten;
  ddc_pkg::ddc_act_clk_t clk_sel;
  ddc_pkg::ddc_lim_in_t lim_in;

  // Address decode for writes
  always_comb begin
    wr_act = 1'b0;
    wr_lim = 1'b0;
    wr_agc = 1'b0;
    wr_pwr = 1'b0;
    if (reg_write && reg_addr == ddc_pkg::DDC_OFS_ACTIVITY_CLOCK_CONFIG) begin
      wr_act = 1'b1;
    end else if (reg_write && reg_addr == ddc_pkg::DDC_OFS_LIMITER_CHANNEL_SELECT) begin
      wr_lim = 1'b1;
    end else if (reg_write && reg_addr == ddc_pkg::DDC_OFS_GAIN_COMPRESSION_CHANNEL_ENABLES) begin
      wr_agc = 1'b1;
    end else if (reg_write && reg_addr == ddc_pkg::DDC_OFS_POWER_LIMITER_CONTROL) begin
      wr_pwr = 1'b1;
    end
  end

  ddc_cfg_reg #(
    .RESET_VALUE(ddc_pkg::DDC_RST_ACTIVITY_CLOCK_CONFIG),
    .WRITE_MASK(ddc_pkg::DDC_WMASK_ACTIVITY_CLOCK_CONFIG)
  ) u_act_cfg (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .wr_en(wr_act),
    .wdata(reg_wdata),
    .q(act_cfg)
  );

  ddc_cfg_reg #(
    .RESET_VALUE(ddc_pkg::DDC_RST_LIMITER_CHANNEL_SELECT),
    .WRITE_MASK(ddc_pkg::DDC_WMASK_LIMITER_CHANNEL_SELECT)
  ) u_lim_cfg (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .wr_en(wr_lim),
    .wdata(reg_wdata),
    .q(lim_cfg)
  );

  ddc_cfg_reg #(
    .RESET_VALUE(ddc_pkg::DDC_RST_GAIN_COMPRESSION_CHANNEL_ENABLES),
    .WRITE_MASK(ddc_pkg::DDC_WMASK_GAIN_COMPRESSION_CHANNEL_ENABLES)
  ) u_agc_cfg (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .wr_en(wr_agc),
    .wdata(reg_wdata),
    .q(agc_cfg)
  );

  ddc_cfg_reg #(
    .RESET_VALUE(ddc_pkg::DDC_RST_POWER_LIMITER_CONTROL),
    .WRITE_MASK(ddc_pkg::DDC_WMASK_POWER_LIMITER_CONTROL)
  ) u_pwr_cfg (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .wr_en(wr_pwr),
    .wdata(reg_wdata),
    .q(pwr_cfg)
  );

  // Read port: one cycle latency, unmapped offsets read zero
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_read;
      if (!reg_read) begin
        reg_rdata <= 8'h00;
      end else if (reg_addr == ddc_pkg::DDC_OFS_ACTIVITY_CLOCK_CONFIG) begin
        reg_rdata <= act_cfg;
      end else if (reg_addr == ddc_pkg::DDC_OFS_LIMITER_CHANNEL_SELECT) begin
        reg_rdata <= lim_cfg;
      end else if (reg_addr == ddc_pkg::DDC_OFS_GAIN_COMPRESSION_CHANNEL_ENABLES) begin
        reg_rdata <= agc_cfg;
      end else if (reg_addr == ddc_pkg::DDC_OFS_POWER_LIMITER_CONTROL) begin
        reg_rdata <= pwr_cfg;
      end else begin
        reg_rdata <= 8'h00;
      end
    end
  end

  assign clk_sel = ddc_pkg::ddc_act_clk_t'(act_cfg[ddc_pkg::DDC_ACT_CLK_SEL_LSB +: 2]);
  assign lim_in = ddc_pkg::ddc_lim_in_t'(lim_cfg[ddc_pkg::DDC_LIM_INP_LSB +: 2]);

  // Activity clock steering
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      activity_clk_use_osc <= 1'b1;
      activity_clk_use_bit_clock <= 1'b0;
      activity_clk_use_control_port_clock <= 1'b0;
      activity_clk_use_custom <= 1'b0;
      activity_ext_clock_rate <= 2'b00;
      activity_ext_clock_khz <= ddc_pkg::DDC_EXT_KHZ_0;
    end else begin
      activity_clk_use_osc <= (clk_sel == ddc_pkg::DDC_CLK_OSC);
      activity_clk_use_bit_clock <= (clk_sel == ddc_pkg::DDC_CLK_BIT_CLOCK);
      activity_clk_use_control_port_clock <= (clk_sel == ddc_pkg::DDC_CLK_CONTROL_CLOCK);
      activity_clk_use_custom <= (clk_sel == ddc_pkg::DDC_CLK_CUSTOM);
      activity_ext_clock_rate <= act_cfg[ddc_pkg::DDC_EXT_RATE_LSB +: 2];
      case (act_cfg[ddc_pkg::DDC_EXT_RATE_LSB +: 2])
        2'b00: activity_ext_clock_khz <= ddc_pkg::DDC_EXT_KHZ_0;
        2'b01: activity_ext_clock_khz <= ddc_pkg::DDC_EXT_KHZ_1;
        2'b10: activity_ext_clock_khz <= ddc_pkg::DDC_EXT_KHZ_2;
        default: activity_ext_clock_khz <= ddc_pkg::DDC_EXT_KHZ_3;
      endcase
    end
  end

  // Pin synchronisers; first stage feeds only the second
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      jack_meta <= 1'b0;
      jack_sync <= 1'b0;
      jack_prev <= 1'b0;
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
    end else begin
      jack_meta <= jack_comparator;
      jack_sync <= jack_meta;
      jack_prev <= jack_sync;
      pin_meta <= attenuation_pin;
      pin_sync <= pin_meta;
    end
  end

  // Rising comparator edge starts phase one only while enabled
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      detect_phase_one_trigger <= 1'b0;
    end else begin
      detect_phase_one_trigger <= jack_sync && !jack_prev &&
        act_cfg[ddc_pkg::DDC_PHASE_ONE_BIT];
    end
  end

  // Limiter detection works on magnitudes; full-scale negative still fits 16 bits
  assign abs_ch0 = playback_channel_zero[15] ? 16'(-playback_channel_zero)
                                              : 16'(playback_channel_zero);
  assign abs_ch1 = playback_channel_one[15] ? 16'(-playback_channel_one)
                                             : 16'(playback_channel_one);
  assign abs_sum = {1'b0, abs_ch0} + {1'b0, abs_ch1};

  always_comb begin
    case (lim_in)
      ddc_pkg::DDC_LIM_IN_MAX: next_level = (abs_ch0 > abs_ch1) ? abs_ch0 : abs_ch1;
      ddc_pkg::DDC_LIM_IN_CH1: next_level = abs_ch1;
      ddc_pkg::DDC_LIM_IN_CH0: next_level = abs_ch0;
      default: next_level = abs_sum[16:1];
    endcase
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      limiter_detect_level <= 16'h0000;
      limiter_apply_ch0 <= 1'b1;
      limiter_apply_ch1 <= 1'b1;
      gain_ctrl_enable <= 4'h0;
      compress_enable <= 4'h0;
    end else begin
      limiter_detect_level <= next_level;
      limiter_apply_ch0 <= (lim_cfg[ddc_pkg::DDC_LIM_OUT_LSB +: 2] == 2'b00) ||
        (lim_cfg[ddc_pkg::DDC_LIM_OUT_LSB +: 2] == 2'b10);
      limiter_apply_ch1 <= (lim_cfg[ddc_pkg::DDC_LIM_OUT_LSB +: 2] == 2'b00) ||
        (lim_cfg[ddc_pkg::DDC_LIM_OUT_LSB +: 2] == 2'b01);
      // Bit 0 of each output is channel one, so the nibbles are reversed
      for (int i = 0; i < 4; i++) begin
        gain_ctrl_enable[i] <= agc_cfg[ddc_pkg::DDC_GAIN_CTRL_LSB + 3 - i];
        compress_enable[i] <= agc_cfg[ddc_pkg::DDC_COMPRESS_LSB + 3 - i];
      end
    end
  end

  // Lower supply reading gives more attenuation
  always_comb begin
    lut_code = 3'd0;
    for (int k = 0; k < 7; k++) begin
      if (analog_reading < ddc_pkg::DDC_SAR_STEP[k]) begin
        lut_code = 3'(k + 1);
      end
    end
  end

  // Pin high means supply low: apply programmed code; pin low means recovered
  always_comb begin
    if (pwr_cfg[ddc_pkg::DDC_PWR_SRC_BIT]) begin
      target_code = lut_code;
      target_update = analog_reading_valid;
    end else begin
      target_code = pin_sync ? pwr_cfg[ddc_pkg::DDC_PWR_ATTN_LSB +: 3] : 3'd0;
      target_update = 1'b1;
    end
    next_atten = power_limiter_attenuation;
    if (!pwr_cfg[ddc_pkg::DDC_PWR_EN_BIT]) begin
      next_atten = 3'd0;
    end else if (target_update && target_code > power_limiter_attenuation) begin
      next_atten = target_code;
    end else if (target_update && target_code < power_limiter_attenuation &&
                 pwr_cfg[ddc_pkg::DDC_PWR_RECOVERY_BIT]) begin
      next_atten = target_code;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      power_limiter_active <= 1'b0;
      power_limiter_attenuation <= 3'd0;
      power_limiter_atten_db <= 6'd0;
    end else begin
      power_limiter_active <= pwr_cfg[ddc_pkg::DDC_PWR_EN_BIT];
      power_limiter_attenuation <= next_atten;
      power_limiter_atten_db <= 6'(next_atten * ddc_pkg::DDC_ATTN_STEP_DB);
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  clk_custom_sel_a: assert property (
    wr_act && reg_wdata[7:6] == 2'b11 |=> ##1 activity_clk_use_custom && !activity_clk_use_osc)
    else $error("custom clock not selected after write");
  clk_bit_sel_a: assert property (
    wr_act && reg_wdata[7:6] == 2'b01 |=> ##1 activity_clk_use_bit_clock &&
      !activity_clk_use_control_port_clock)
    else $error("bit clock not selected after write");
  ext_rate_khz_a: assert property (
    wr_act && reg_wdata[5:4] == 2'b01 |=> ##1 activity_ext_clock_khz == 16'd6144)
    else $error("external rate mismatch");
  phase_one_gate_a: assert property (
    detect_phase_one_trigger |-> $past(act_cfg[2]) && $past(jack_sync) && !$past(jack_prev))
    else $error("phase one trigger without enable or edge");
  reserved_zero_a: assert property (
    (act_cfg & 8'h0b) == 8'h00 && lim_cfg[3:0] == 4'h0 && pwr_cfg[1:0] == 2'b00)
    else $error("reserved bit set");
  lim_avg_a: assert property (
    lim_in == ddc_pkg::DDC_LIM_IN_AVG && !wr_lim |=> limiter_detect_level == $past(abs_sum[16:1]))
    else $error("limiter average wrong");
  lim_none_a: assert property (
    wr_lim && reg_wdata[5:4] == 2'b11 |=> ##1 !limiter_apply_ch0 && !limiter_apply_ch1)
    else $error("limiter applied with none selected");
  agc_order_a: assert property (
    wr_agc |=> ##1 gain_ctrl_enable[0] == $past(reg_wdata[7], 2) &&
      compress_enable[3] == $past(reg_wdata[0], 2))
    else $error("channel enable order wrong");
  pwr_bypass_a: assert property (
    !pwr_cfg[7] |=> power_limiter_attenuation == 3'd0 && power_limiter_atten_db == 6'd0)
    else $error("attenuation while bypassed");
  atten_db_a: assert property (
    power_limiter_atten_db == 6'(power_limiter_attenuation * 6'd6))
    else $error("attenuation dB mismatch");
  no_recover_a: assert property (
    pwr_cfg[7] && !pwr_cfg[2] && !wr_pwr |=> power_limiter_attenuation >=
      $past(power_limiter_attenuation))
    else $error("attenuation fell without recovery");
  readback_a: assert property (
    wr_agc ##1 (reg_read && !reg_write && reg_addr == 8'h24) |=>
      reg_rvalid && reg_rdata == $past(reg_wdata, 2))
    else $error("readback mismatch");

  phase_one_c: cover property (detect_phase_one_trigger);
  atten_max_c: cover property (power_limiter_atten_db == 6'd42);
  atten_recover_c: cover property (pwr_cfg[2] && $fell(power_limiter_attenuation != 3'd0));
  custom_clk_c: cover property (activity_clk_use_custom);

endmodule

//--- hdl/ddc_pkg.sv
package ddc_pkg;

  // Register offsets on the control port
  localparam logic [7:0] DDC_OFS_ACTIVITY_CLOCK_CONFIG = 8'h20;
  localparam logic [7:0] DDC_OFS_LIMITER_CHANNEL_SELECT = 8'h23;
  localparam logic [7:0] DDC_OFS_GAIN_COMPRESSION_CHANNEL_ENABLES = 8'h24;
  localparam logic [7:0] DDC_OFS_POWER_LIMITER_CONTROL = 8'h2b;

  // Reset values
  localparam logic [7:0] DDC_RST_ACTIVITY_CLOCK_CONFIG = 8'h00;
  localparam logic [7:0] DDC_RST_LIMITER_CHANNEL_SELECT = 8'h00;
  localparam logic [7:0] DDC_RST_GAIN_COMPRESSION_CHANNEL_ENABLES = 8'h00;
  localparam logic [7:0] DDC_RST_POWER_LIMITER_CONTROL = 8'h00;

  // Writable bits; reserved bits stay zero
  localparam logic [7:0] DDC_WMASK_ACTIVITY_CLOCK_CONFIG = 8'hf4;
  localparam logic [7:0] DDC_WMASK_LIMITER_CHANNEL_SELECT = 8'hf0;
  localparam logic [7:0] DDC_WMASK_GAIN_COMPRESSION_CHANNEL_ENABLES = 8'hff;
  localparam logic [7:0] DDC_WMASK_POWER_LIMITER_CONTROL = 8'hfc;

  // Field positions
  localparam int DDC_ACT_CLK_SEL_LSB = 6;
  localparam int DDC_EXT_RATE_LSB = 4;
  localparam int DDC_PHASE_ONE_BIT = 2;
  localparam int DDC_LIM_INP_LSB = 6;
  localparam int DDC_LIM_OUT_LSB = 4;
  localparam int DDC_GAIN_CTRL_LSB = 4;
  localparam int DDC_COMPRESS_LSB = 0;
  localparam int DDC_PWR_EN_BIT = 7;
  localparam int DDC_PWR_ATTN_LSB = 4;
  localparam int DDC_PWR_SRC_BIT = 3;
  localparam int DDC_PWR_RECOVERY_BIT = 2;

  typedef enum logic [1:0] {
    DDC_CLK_OSC = 2'b00,
    DDC_CLK_BIT_CLOCK = 2'b01,
    DDC_CLK_CONTROL_CLOCK = 2'b10,
    DDC_CLK_CUSTOM = 2'b11
  } ddc_act_clk_t;

  typedef enum logic [1:0] {
    DDC_LIM_IN_MAX = 2'b00,
    DDC_LIM_IN_CH1 = 2'b01,
    DDC_LIM_IN_CH0 = 2'b10,
    DDC_LIM_IN_AVG = 2'b11
  } ddc_lim_in_t;

  // External clock rates in kHz, indexed by rate code
  localparam logic [15:0] DDC_EXT_KHZ_0 = 16'd24576;
  localparam logic [15:0] DDC_EXT_KHZ_1 = 16'd6144;
  localparam logic [15:0] DDC_EXT_KHZ_2 = 16'd12288;
  localparam logic [15:0] DDC_EXT_KHZ_3 = 16'd18432;

  // Attenuation step in dB per code
  localparam logic [5:0] DDC_ATTN_STEP_DB = 6'd6;

  // Analog reading thresholds: below entry k means attenuation code k+1
  localparam logic [7:0] DDC_SAR_STEP [7] = '{8'hc0, 8'hb8, 8'hb0, 8'ha8, 8'ha0, 8'h98, 8'h90};

endpackage

//--- tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic clk_sys, reset_n, reg_write, reg_read, rvalid, jack, pin, av;
  logic [7:0] addr, wdata, rdata, areading;
  logic signed [15:0] s0, s1;
  logic osc, bclk, ctlclk, cust, trig, ap0, ap1, pact;
  logic [1:0] rate;
  logic [15:0] khz, lvl;
  logic [3:0] gce, cpe;
  logic [2:0] att;
  logic [5:0] db;
  int errors = 0;
  int tests_run = 0;
  integer seed = 6;

  ddc_dynamics_config ddc_dynamics_config_i (
    .clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(addr), .reg_wdata(wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(rdata), .reg_rvalid(rvalid),
    .jack_comparator(jack), .attenuation_pin(pin), .analog_reading(areading),
    .analog_reading_valid(av), .playback_channel_zero(s0), .playback_channel_one(s1),
    .activity_clk_use_osc(osc), .activity_clk_use_bit_clock(bclk),
    .activity_clk_use_control_port_clock(ctlclk), .activity_clk_use_custom(cust),
    .activity_ext_clock_rate(rate), .activity_ext_clock_khz(khz),
    .detect_phase_one_trigger(trig), .limiter_detect_level(lvl),
    .limiter_apply_ch0(ap0), .limiter_apply_ch1(ap1), .gain_ctrl_enable(gce),
    .compress_enable(cpe), .power_limiter_active(pact),
    .power_limiter_attenuation(att), .power_limiter_atten_db(db)
  );

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic close_out;
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  // Strobe held high for one cycle, then low for one cycle so back-to-back calls give separate pulses
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    reg_write = 1'b1;
    cyc(1);
    reg_write = 1'b0;
    cyc(1);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    int n;
    addr = a;
    reg_read = 1'b1;
    cyc(1);
    reg_read = 1'b0;
    n = 0;
    while (rvalid !== 1'b1 && n < 4) begin
      cyc(1);
      n++;
    end
    if (rvalid !== 1'b1) begin
      errors++;
      close_out();
    end
    check(rdata, exp, "read data");
    cyc(1);
  endtask

  function automatic logic [15:0] mag(input logic signed [15:0] v);
    return v[15] ? 16'(-v) : 16'(v);
  endfunction

  function automatic logic [15:0] lev(input logic [1:0] sel, input logic signed [15:0] a,
                                      input logic signed [15:0] b);
    logic [16:0] sum;
    sum = {1'b0, mag(a)} + {1'b0, mag(b)};
    case (sel)
      2'd0: return (mag(a) > mag(b)) ? mag(a) : mag(b);
      2'd1: return mag(b);
      2'd2: return mag(a);
      default: return sum[16:1];
    endcase
  endfunction

  function automatic logic [2:0] lut(input logic [7:0] r);
    logic [2:0] c;
    c = 3'd0;
    for (int k = 0; k < 7; k++) begin
      if (r < ddc_pkg::DDC_SAR_STEP[k]) c = 3'(k + 1);
    end
    return c;
  endfunction

  // Guard against a hung handshake
  initial begin
    #500000;
    errors++;
    close_out();
  end

  initial begin
    logic [7:0] d;
    logic [7:0] ofs [4];
    logic [7:0] msk [4];
    logic [15:0] kt [4];
    logic [7:0] sar [5];
    int n, at;
    ofs = '{8'h20, 8'h23, 8'h24, 8'h2b};
    msk = '{8'hf4, 8'hf0, 8'hff, 8'hfc};
    kt = '{16'd24576, 16'd6144, 16'd12288, 16'd18432};
    sar = '{8'hc0, 8'hbf, 8'h98, 8'h8f, 8'hff};
    reset_n = 1'b0;
    reg_write = 1'b0;
    reg_read = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    jack = 1'b0;
    pin = 1'b0;
    av = 1'b0;
    areading = 8'hff;
    s0 = 16'sh0000;
    s1 = 16'sh0000;
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    reset_n = 1'b1;
    cyc(1);
    check({osc, bclk, ctlclk, cust}, 4'b1000, "reset clock sel");
    check(khz, 16'd24576, "reset khz");
    check({ap1, ap0, pact, att, gce, cpe}, 14'h3000, "reset outputs");
    for (int i = 0; i < 4; i++) begin
      rdchk(ofs[i], 8'h00);
      // Reserved bits are only ever written as zero
      wr(ofs[i], msk[i]);
      rdchk(ofs[i], msk[i]);
      d = 8'($random(seed)) & msk[i];
      wr(ofs[i], d);
      rdchk(ofs[i], d & msk[i]);
      wr(ofs[i], 8'h00);
    end
    wr(8'h21, 8'hff);
    rdchk(8'h21, 8'h00);
    for (int i = 0; i < 4; i++) begin
      wr(8'h20, 8'((i << 6) | ((3 - i) << 4)));
      check({osc, bclk, ctlclk, cust}, 16'(4'b1000 >> i), "clock sel");
      check(rate, 16'(3 - i), "rate");
      check(khz, kt[3 - i], "khz");
    end
    for (int i = 0; i < 12; i++) begin
      wr(8'h23, 8'(((i % 4) << 6) | ((i % 4) << 4)));
      s0 = (i < 4) ? 16'sh8000 : 16'($random(seed));
      s1 = (i < 4) ? 16'sh7fff : 16'($random(seed));
      cyc(2);
      check(lvl, lev(2'(i % 4), s0, s1), "detect level");
      check({ap1, ap0}, 16'(3 - (i % 4)), "apply");
    end
    for (int i = 0; i < 8; i++) begin
      d = (i == 0) ? 8'h81 : 8'($random(seed));
      wr(8'h24, d);
      check(gce, {d[4], d[5], d[6], d[7]}, "gain enables");
      check(cpe, {d[0], d[1], d[2], d[3]}, "compress enables");
    end
    // Read straight after a write must see the new value
    addr = 8'h24;
    wdata = 8'h5a;
    reg_write = 1'b1;
    cyc(1);
    reg_write = 1'b0;
    reg_read = 1'b1;
    cyc(1);
    reg_read = 1'b0;
    check({7'h00, rvalid, rdata}, 16'h015a, "write then read");
    cyc(1);
    for (int e = 0; e < 2; e++) begin
      wr(8'h20, 8'(e << 2));
      jack = 1'b1;
      n = 0;
      at = 0;
      for (int k = 0; k < 6; k++) begin
        cyc(1);
        if (trig === 1'b1) begin
          n++;
          at = k;
        end
      end
      check(16'(n), 16'(e), "trigger count");
      check(16'(at), 16'(2 * e), "trigger cycle");
      jack = 1'b0;
      cyc(4);
    end
    pin = 1'b1;
    for (int c = 0; c < 8; c++) begin
      wr(8'h2b, 8'(8'h80 | (c << 4)));
      cyc(4);
      check(att, 16'(c), "attn code");
      check(db, 16'(c * 6), "attn db");
      check(pact, 1'b1, "active");
    end
    wr(8'h2b, 8'h70);
    cyc(2);
    check({pact, att, db}, 16'h0, "bypass");
    wr(8'h2b, 8'hd0);
    cyc(4);
    check(att, 3'd5, "pin attn");
    pin = 1'b0;
    cyc(6);
    check(att, 3'd5, "no recovery");
    wr(8'h2b, 8'hd4);
    cyc(4);
    check(att, 3'd0, "recovered");
    // Pin high and code 7 so a wrong source choice shows up
    pin = 1'b1;
    wr(8'h2b, 8'hfc);
    for (int i = 0; i < 10; i++) begin
      areading = (i < 5) ? sar[i] : 8'($random(seed));
      av = 1'b1;
      cyc(1);
      av = 1'b0;
      cyc(4);
      check(att, lut(areading), "analog attn");
    end
    close_out();
  end
endmodule
